// File: hdl/pmu_power_sequencer.sv
// Purpose: Power-up, shutdown and control pin logic of a phone PMU
// Assumes: All inputs synchronous to i_mclk; analog levels arrive as comparator flags
// Notes: Serial port pins are open drain, sampled directly each clock
`timescale 1ns/1ps

// Overview of operation
// RULE1 - Serial slave only, address 1010101, byte access
// RULE2 - Start, address, ack, register, ack, data, ack, stop
// RULE3 - Button, charger or headset starts the sequence
// RULE4 - Staged variant: buck first, regulator one later
// RULE5 - Other variant: buck and regulators together
// RULE6 - Reset low at regulator one 87%, 65ms
// RULE7 - Release reset only if both within window
// RULE8 - Otherwise hold reset until both in window
// RULE9 - Processor raises keep-alive after its power-up
// RULE10 - Button released before keep-alive shuts down
// RULE11 - Processor may delay keep-alive for longer hold
// RULE12 - Later regulators follow inputs or register bits
// RULE13 - Second button press drives interrupt low
// RULE14 - Processor drops keep-alive to finish shutdown
// RULE15 - Buck on while headset, button, keep-alive; bit
// RULE16 - Switch outputs follow their control inputs
// RULE17 - Supply-present sinks while charger above 4V
// RULE18 - Overtemperature disables all until cooled down
module pmu_power_sequencer #(
  parameter int RESET_HOLD_CYCLES = pmu_seq_pkg::RESET_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Wake sources and processor control
  input wire logic i_power_button_in,
  input wire logic i_charger_supply_in,
  input wire logic i_headset_detect_in,
  input wire logic i_keep_alive_in,
  input wire logic i_osc_supply_enable_in,
  input wire logic i_rx_enable_in,
  input wire logic i_tx_enable_in,
  input wire logic i_variant_staged,
  // Analog comparator flags
  input wire logic i_buck_at_87,
  input wire logic i_linear_one_at_87,
  input wire logic i_buck_in_window,
  input wire logic i_linear_one_in_window,
  input wire logic i_over_temp,
  input wire logic i_temp_cooled,
  // Switch controls
  input wire logic i_switch_control_in_a,
  input wire logic i_switch_control_in_b,
  // Serial control port
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Regulator enables
  output logic o_buck_en,
  output logic o_linear_reg_one_en,
  output logic o_linear_reg_four_en,
  output logic o_linear_reg_five_en,
  output logic o_linear_reg_six_en,
  output logic o_linear_reg_seven_en,
  output logic o_linear_reg_eight_en,
  // System pins
  output logic o_cpu_reset_n,
  output logic o_button_irq_n,
  output logic o_switch_out_a_oe,
  output logic o_switch_out_b_oe,
  output logic o_supply_present_n_oe,
  output logic o_charger_valid
);
  import pmu_seq_pkg::*;

  pwr_state_e pstate, next_pstate;
  logic [HOLD_CNT_W-1:0] hold_cnt, next_hold_cnt;
  logic btn_prev, next_btn_prev;
  logic irq, next_irq;
  logic buck_en, next_buck_en;
  logic lin1_en, next_lin1_en;
  logic lin78_en, next_lin78_en;
  logic [2:0] lin456_en, next_lin456_en;
  logic reset_n, next_reset_n;

  ser_state_e sstate, next_sstate;
  logic scl_q, sda_q;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic [7:0] reg_addr, next_reg_addr;
  logic rw, next_rw;
  logic sda_oe, next_sda_oe;
  logic buck_on, next_buck_on;
  logic [2:0] ldo_en, next_ldo_en;

  logic scl_rise, scl_fall, bus_start, bus_stop, wake;

  function automatic logic [7:0] read_mux(input logic [7:0] addr);
    case (addr)
      BUCK_CTRL_ADDR: read_mux = {6'h0, i_buck_in_window, buck_on};
      LDO_CTRL_ADDR: read_mux = {5'h0, ldo_en};
      STATUS_ADDR: read_mux = {i_charger_supply_in, i_headset_detect_in,
                               i_keep_alive_in, 2'h0, pstate};
      default: read_mux = 8'h00;
    endcase
  endfunction

  assign wake = i_power_button_in | i_charger_supply_in | i_headset_detect_in;
  assign scl_rise = i_scl & ~scl_q;
  assign scl_fall = ~i_scl & scl_q;
  assign bus_start = scl_q & i_scl & sda_q & ~i_sda;
  assign bus_stop = scl_q & i_scl & ~sda_q & i_sda;

  // Power sequencing
  always_comb begin
    next_pstate = pstate;
    next_hold_cnt = hold_cnt;
    next_btn_prev = i_power_button_in;
    next_irq = 1'b0;
    case (pstate)
      P_OFF: begin
        if (wake) begin // see RULE3
          next_pstate = i_variant_staged ? P_BUCK_RAMP : P_LIN1_RAMP; // see RULE4 see RULE5
        end
      end
      P_BUCK_RAMP: begin
        if (i_buck_at_87) begin // see RULE4
          next_pstate = P_LIN1_RAMP;
        end
      end
      P_LIN1_RAMP: begin
        next_hold_cnt = '0;
        if (i_linear_one_at_87) begin // see RULE6
          next_pstate = P_RESET_HOLD;
        end
      end
      P_RESET_HOLD: begin
        next_hold_cnt = hold_cnt + 1'b1;
        if (hold_cnt == HOLD_CNT_W'(RESET_HOLD_CYCLES - 1)) begin // see RULE6
          next_pstate = P_RESET_CHECK;
        end
      end
      P_RESET_CHECK: begin
        if (i_buck_in_window && i_linear_one_in_window) begin // see RULE7 see RULE8
          next_pstate = P_WAIT_HOLD;
        end
      end
      P_WAIT_HOLD: begin
        if (i_keep_alive_in) begin // see RULE9 see RULE11
          next_pstate = P_ON;
        end else if (!wake) begin // see RULE10
          next_pstate = P_OFF;
        end
      end
      P_ON: begin
        next_irq = irq ? i_power_button_in : (i_power_button_in & ~btn_prev); // see RULE13
        if (!i_keep_alive_in && !i_power_button_in && !i_headset_detect_in) begin // see RULE14
          next_pstate = P_OFF;
        end
      end
      P_THERMAL: begin
        if (i_temp_cooled) begin // see RULE18
          next_pstate = P_OFF;
        end
      end
      default: next_pstate = P_OFF;
    endcase
    // Wake source gone mid-sequence: abandon startup
    if (pstate inside {P_BUCK_RAMP, P_LIN1_RAMP, P_RESET_HOLD, P_RESET_CHECK} && !wake) begin // see RULE10
      next_pstate = P_OFF;
    end
    if (i_over_temp) begin // see RULE18
      next_pstate = P_THERMAL;
      next_irq = 1'b0;
    end
    next_buck_en = 1'b0;
    next_lin1_en = 1'b0;
    next_lin78_en = 1'b0;
    next_lin456_en = 3'h0;
    next_reset_n = 1'b0;
    case (next_pstate)
      P_OFF, P_THERMAL: begin
        next_reset_n = 1'b0;
      end
      P_BUCK_RAMP: begin
        next_buck_en = buck_on;
        next_lin78_en = 1'b1;
      end
      P_ON: begin
        next_buck_en = buck_on &
                       (i_headset_detect_in | i_power_button_in | i_keep_alive_in); // see RULE15
        next_lin1_en = i_keep_alive_in; // see RULE12
        next_lin78_en = 1'b1;
        next_lin456_en = ldo_en |
                         {i_tx_enable_in, i_rx_enable_in, i_osc_supply_enable_in}; // see RULE12
        next_reset_n = 1'b1;
      end
      default: begin
        next_buck_en = buck_on; // see RULE15
        next_lin1_en = 1'b1;
        next_lin78_en = 1'b1;
        next_reset_n = (next_pstate == P_WAIT_HOLD); // see RULE7
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pstate <= P_OFF;
      hold_cnt <= '0;
      btn_prev <= 1'b0;
      irq <= 1'b0;
      buck_en <= 1'b0;
      lin1_en <= 1'b0;
      lin78_en <= 1'b0;
      lin456_en <= 3'h0;
      reset_n <= 1'b0;
    end else begin
      pstate <= next_pstate;
      hold_cnt <= next_hold_cnt;
      btn_prev <= next_btn_prev;
      irq <= next_irq;
      buck_en <= next_buck_en;
      lin1_en <= next_lin1_en;
      lin78_en <= next_lin78_en;
      lin456_en <= next_lin456_en;
      reset_n <= next_reset_n;
    end
  end

  // Serial slave
  always_comb begin
    next_sstate = sstate;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_reg_addr = reg_addr;
    next_rw = rw;
    next_sda_oe = sda_oe;
    next_buck_on = buck_on;
    next_ldo_en = ldo_en;
    if (scl_rise && (sstate == S_ADDR || sstate == S_REG || sstate == S_DATA)) begin
      next_shift = {shift[6:0], i_sda}; // see RULE2
      next_bit_cnt = bit_cnt + 1'b1;
      if (sstate == S_DATA && bit_cnt == BITS_PER_BYTE - 1'b1) begin
        case (reg_addr) // see RULE1 see RULE2
          BUCK_CTRL_ADDR: next_buck_on = i_sda;
          LDO_CTRL_ADDR: next_ldo_en = {shift[1:0], i_sda};
          default: next_ldo_en = ldo_en;
        endcase
      end
    end
    if (scl_rise && sstate == S_TX) begin
      next_bit_cnt = bit_cnt + 1'b1;
    end
    if (scl_fall) begin
      case (sstate)
        S_ADDR: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            if (shift[7:1] == SLAVE_ADDR) begin // see RULE1
              next_rw = shift[0];
              next_sda_oe = 1'b1;
              next_sstate = S_ADDR_ACK;
            end else begin
              next_sstate = S_IDLE;
            end
          end
        end
        S_ADDR_ACK: begin
          next_sda_oe = 1'b0;
          next_bit_cnt = 4'h0;
          next_sstate = S_REG;
        end
        S_REG: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            next_reg_addr = shift;
            next_sda_oe = 1'b1;
            next_sstate = S_REG_ACK;
          end
        end
        S_REG_ACK: begin
          next_bit_cnt = 4'h0;
          if (rw) begin
            next_shift = read_mux(reg_addr);
            next_sda_oe = ~next_shift[7];
            next_sstate = S_TX;
          end else begin
            next_sda_oe = 1'b0;
            next_sstate = S_DATA;
          end
        end
        S_DATA: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            next_sda_oe = 1'b1;
            next_sstate = S_DATA_ACK;
          end
        end
        S_TX: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            next_sda_oe = 1'b0;
            next_sstate = S_TX_ACK;
          end else begin
            next_shift = {shift[6:0], 1'b0};
            next_sda_oe = ~shift[6];
          end
        end
        S_DATA_ACK, S_TX_ACK: begin
          next_sda_oe = 1'b0;
          next_sstate = S_IDLE;
        end
        default: next_sstate = sstate;
      endcase
    end
    if (bus_start) begin
      next_sstate = S_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (bus_stop) begin
      next_sstate = S_IDLE;
      next_sda_oe = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sstate <= S_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      reg_addr <= 8'h00;
      rw <= 1'b0;
      sda_oe <= 1'b0;
      buck_on <= BUCK_ON_RESET;
      ldo_en <= LDO_EN_RESET;
    end else begin
      sstate <= next_sstate;
      scl_q <= i_scl;
      sda_q <= i_sda;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      reg_addr <= next_reg_addr;
      rw <= next_rw;
      sda_oe <= next_sda_oe;
      buck_on <= next_buck_on;
      ldo_en <= next_ldo_en;
    end
  end

  // Pin outputs, all registered
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
      o_buck_en <= 1'b0;
      o_linear_reg_one_en <= 1'b0;
      o_linear_reg_four_en <= 1'b0;
      o_linear_reg_five_en <= 1'b0;
      o_linear_reg_six_en <= 1'b0;
      o_linear_reg_seven_en <= 1'b0;
      o_linear_reg_eight_en <= 1'b0;
      o_cpu_reset_n <= 1'b0;
      o_button_irq_n <= 1'b1;
      o_switch_out_a_oe <= 1'b0;
      o_switch_out_b_oe <= 1'b0;
      o_supply_present_n_oe <= 1'b0;
      o_charger_valid <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
      o_sda_oe <= next_sda_oe;
      o_buck_en <= buck_en;
      o_linear_reg_one_en <= lin1_en;
      o_linear_reg_four_en <= lin456_en[0];
      o_linear_reg_five_en <= lin456_en[1];
      o_linear_reg_six_en <= lin456_en[2];
      o_linear_reg_seven_en <= lin78_en;
      o_linear_reg_eight_en <= lin78_en;
      o_cpu_reset_n <= reset_n; // see RULE6 see RULE7
      o_button_irq_n <= ~irq; // see RULE13
      o_switch_out_a_oe <= i_switch_control_in_a; // see RULE16
      o_switch_out_b_oe <= i_switch_control_in_b; // see RULE16
      o_supply_present_n_oe <= i_charger_supply_in; // see RULE17
      o_charger_valid <= i_charger_supply_in;
    end
  end
endmodule // pmu_power_sequencer

// File: shared/pmu_seq_pkg.sv
// Purpose: Shared constants and state types for the power sequencer
// Assumes: 125 MHz design clock
// Notes: Register offsets are byte addresses on the serial control port
package pmu_seq_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_HOLD_MS = 65;
  localparam int RESET_HOLD_CYCLES =
    (RESET_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CNT_W = 24;

  localparam logic [6:0] SLAVE_ADDR = 7'h55;
  localparam logic [7:0] BUCK_CTRL_ADDR = 8'h17;
  localparam logic [7:0] LDO_CTRL_ADDR = 8'h20;
  localparam logic [7:0] STATUS_ADDR = 8'h21;
  localparam int BUCK_ON_BIT = 0;
  localparam int BUCK_OK_BIT = 1;
  localparam logic BUCK_ON_RESET = 1'b1;
  localparam logic [2:0] LDO_EN_RESET = 3'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    P_OFF = 3'b000,
    P_BUCK_RAMP = 3'b001,
    P_LIN1_RAMP = 3'b010,
    P_RESET_HOLD = 3'b011,
    P_RESET_CHECK = 3'b100,
    P_WAIT_HOLD = 3'b101,
    P_ON = 3'b110,
    P_THERMAL = 3'b111
  } pwr_state_e;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_ADDR = 4'b0001,
    S_ADDR_ACK = 4'b0010,
    S_REG = 4'b0011,
    S_REG_ACK = 4'b0100,
    S_DATA = 4'b0101,
    S_DATA_ACK = 4'b0110,
    S_TX = 4'b0111,
    S_TX_ACK = 4'b1000
  } ser_state_e;
endpackage

// File: verif/pmu_seq_checker.sv
// Purpose: Port assertions for the power sequencer
// Assumes: Flags held steady by the stimulus
// Notes: Bound to every sequencer instance
`timescale 1ns/1ps
module pmu_seq_checker #(
  parameter int RESET_HOLD_CYCLES = 20
) (
  // Clock and inputs
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_power_button_in,
  input wire logic i_charger_supply_in,
  input wire logic i_headset_detect_in,
  input wire logic i_keep_alive_in,
  input wire logic i_variant_staged,
  input wire logic i_buck_at_87,
  input wire logic i_linear_one_at_87,
  input wire logic i_buck_in_window,
  input wire logic i_linear_one_in_window,
  input wire logic i_over_temp,
  input wire logic i_switch_control_in_a,
  input wire logic i_switch_control_in_b,
  // Outputs
  input wire logic o_buck_en,
  input wire logic o_linear_reg_one_en,
  input wire logic o_linear_reg_four_en,
  input wire logic o_linear_reg_five_en,
  input wire logic o_linear_reg_six_en,
  input wire logic o_linear_reg_seven_en,
  input wire logic o_linear_reg_eight_en,
  input wire logic o_cpu_reset_n,
  input wire logic o_button_irq_n,
  input wire logic o_switch_out_a_oe,
  input wire logic o_switch_out_b_oe,
  input wire logic o_supply_present_n_oe,
  input wire logic o_charger_valid
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  wire logic wake = i_power_button_in | i_charger_supply_in | i_headset_detect_in;
  wire logic any_en = o_buck_en | o_linear_reg_one_en | o_linear_reg_four_en |
    o_linear_reg_five_en | o_linear_reg_six_en | o_linear_reg_seven_en | o_linear_reg_eight_en;
  logic [31:0] at87_cnt;
  logic [31:0] next_at87_cnt;
  // Cycles the regulator-one flag has stood high
  always_comb begin
    next_at87_cnt = i_linear_one_at_87 ? at87_cnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge i_mclk) begin
    at87_cnt <= i_rst ? 32'h0 : next_at87_cnt;
  end
  chk_wake_start: assert property (
    $rose(o_buck_en) |-> $past(wake | i_keep_alive_in, 2)) else $error("buck rose without wake");
  chk_staged_order: assert property (
    $rose(o_linear_reg_one_en) && i_variant_staged |-> $past(i_buck_at_87, 2) && $past(o_buck_en))
    else $error("regulator one early");
  chk_joint_start: assert property (
    $rose(o_buck_en) && !i_variant_staged |->
    o_linear_reg_one_en && o_linear_reg_seven_en && o_linear_reg_eight_en)
    else $error("joint start broken");
  chk_hold_time: assert property (
    $rose(o_cpu_reset_n) |-> at87_cnt >= RESET_HOLD_CYCLES) else $error("reset hold short");
  chk_window_gate: assert property (
    $rose(o_cpu_reset_n) |-> $past(i_buck_in_window, 2) && $past(i_linear_one_in_window, 2))
    else $error("reset released out of window");
  chk_press_irq: assert property (
    $fell(o_button_irq_n) |-> $past(i_power_button_in, 2) && !$past(i_power_button_in, 3))
    else $error("irq without press");
  chk_buck_idle: assert property (
    (!wake && !i_keep_alive_in)[*3] |-> !o_buck_en) else $error("buck on without source");
  chk_switch_a_on: assert property (
    i_switch_control_in_a[*3] |-> o_switch_out_a_oe) else $error("switch a off");
  chk_switch_b_off: assert property (
    !i_switch_control_in_b[*3] |-> !o_switch_out_b_oe) else $error("switch b on");
  chk_supply_flag: assert property (
    i_charger_supply_in[*3] |-> o_supply_present_n_oe && o_charger_valid)
    else $error("supply flag missing");
  chk_thermal_off: assert property (
    i_over_temp[*3] |-> !any_en && !o_cpu_reset_n) else $error("regulator on while hot");
  cov_release: cover property ($rose(o_cpu_reset_n));
  cov_irq: cover property ($fell(o_button_irq_n));
  cov_hot: cover property (i_over_temp[*3]);
endmodule // pmu_seq_checker

bind pmu_power_sequencer pmu_seq_checker #(
  .RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)
) chk_inst (.*);

// File: verif/cpu_model.sv
// Purpose: Processor side of the power sequencer
// Assumes: Boot takes i_boot_delay + 1 cycles after reset release
// Notes: Never raises keep-alive twice in one power cycle
`timescale 1ns/1ps
module cpu_model (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Device pins
  input wire logic i_cpu_reset_n,
  input wire logic i_button_irq_n,
  input wire logic i_headset_detect_in,
  input wire logic i_charger_valid,
  input wire logic [7:0] i_boot_delay,
  // Keep-alive
  output logic o_keep_alive_in
);
  logic [7:0] boot_cnt;
  logic booted;
  always_ff @(posedge i_mclk) begin
    if (i_rst || !i_cpu_reset_n) begin
      boot_cnt <= 8'h00;
      booted <= 1'b0;
      o_keep_alive_in <= 1'b0;
    end else if (!booted) begin
      booted <= (boot_cnt == i_boot_delay);
      o_keep_alive_in <= (boot_cnt == i_boot_delay);
      boot_cnt <= boot_cnt + 8'h01;
    end else if (!i_button_irq_n && !i_headset_detect_in && !i_charger_valid) begin
      o_keep_alive_in <= 1'b0;
    end
  end
endmodule // cpu_model

// File: verif/pmu_power_sequencer_bench.sv
// Purpose: Self-checking bench for the power sequencer
// Assumes: Short reset hold keeps the run brief
// Notes: Serial lines idle high outside the serial test; SDA is a wired AND
`timescale 1ns/1ps
module pmu_power_sequencer_bench;
  import pmu_seq_pkg::*;
  localparam int HOLD = 20;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_scl = 1'b1;
  logic sda_drv = 1'b1;
  logic i_power_button_in, i_charger_supply_in, i_headset_detect_in, i_keep_alive_in;
  logic i_osc_supply_enable_in, i_rx_enable_in, i_tx_enable_in, i_variant_staged;
  logic i_buck_at_87, i_linear_one_at_87, i_buck_in_window, i_linear_one_in_window;
  logic i_over_temp, i_temp_cooled, i_switch_control_in_a, i_switch_control_in_b;
  logic o_sda_out, o_sda_oe, o_buck_en, o_linear_reg_one_en, o_linear_reg_four_en;
  logic o_linear_reg_five_en, o_linear_reg_six_en, o_linear_reg_seven_en;
  logic o_linear_reg_eight_en, o_cpu_reset_n, o_button_irq_n, o_switch_out_a_oe;
  logic o_switch_out_b_oe, o_supply_present_n_oe, o_charger_valid;
  wire logic i_sda = sda_drv & ~o_sda_oe;
  logic [7:0] boot_delay = 8'h04;
  int err_count = 0;
  int check_count = 0;
  wire logic [6:0] en = {o_buck_en, o_linear_reg_one_en, o_linear_reg_four_en,
    o_linear_reg_five_en, o_linear_reg_six_en, o_linear_reg_seven_en, o_linear_reg_eight_en};

  pmu_power_sequencer #(.RESET_HOLD_CYCLES(HOLD)) dut (.*);
  cpu_model cpu (.i_mclk(i_mclk), .i_rst(i_rst), .i_cpu_reset_n(o_cpu_reset_n),
    .i_button_irq_n(o_button_irq_n), .i_headset_detect_in(i_headset_detect_in),
    .i_charger_valid(o_charger_valid), .i_boot_delay(boot_delay),
    .o_keep_alive_in(i_keep_alive_in));

  always #4 i_mclk = ~i_mclk;

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < 500) begin
      @(posedge i_mclk);
      k++;
    end
    if (s !== v) begin
      err_count++;
      final_report();
    end
  endtask
  task automatic do_reset;
    i_rst <= 1'b1;
    {i_power_button_in, i_charger_supply_in, i_headset_detect_in, i_osc_supply_enable_in,
      i_rx_enable_in, i_tx_enable_in, i_variant_staged, i_buck_at_87, i_linear_one_at_87,
      i_buck_in_window, i_linear_one_in_window, i_over_temp, i_temp_cooled,
      i_switch_control_in_a, i_switch_control_in_b} <= 15'h0000;
    cyc(3);
    i_rst <= 1'b0;
    cyc(1);
  endtask
  task automatic t_wake;
    do_reset();
    i_charger_supply_in <= 1'b1;
    cyc(4);
    chk({o_buck_en, o_supply_present_n_oe, o_charger_valid}, 8'h07);
    do_reset();
    i_headset_detect_in <= 1'b1;
    i_switch_control_in_a <= 1'b1;
    cyc(4);
    chk({o_buck_en, o_switch_out_a_oe, o_switch_out_b_oe, o_supply_present_n_oe}, 8'h0c);
    i_switch_control_in_a <= 1'b0;
    i_switch_control_in_b <= 1'b1;
    cyc(4);
    chk({o_switch_out_a_oe, o_switch_out_b_oe}, 8'h01);
    $display("wake test done");
  endtask
  task automatic t_boot(input logic staged);
    do_reset();
    i_variant_staged <= staged;
    cyc(1);
    i_power_button_in <= 1'b1;
    cyc(4);
    chk(en, staged ? 8'h43 : 8'h63);
    i_buck_at_87 <= 1'b1;
    cyc(4);
    chk({en, o_cpu_reset_n}, 8'hc6);
    i_linear_one_at_87 <= 1'b1;
    cyc(HOLD + 8);
    chk(o_cpu_reset_n, 1'b0);
    i_buck_in_window <= 1'b1;
    cyc(4);
    chk(o_cpu_reset_n, 1'b0);
    i_linear_one_in_window <= 1'b1;
    wait_for(o_cpu_reset_n, 1'b1);
    wait_for(i_keep_alive_in, 1'b1);
    i_osc_supply_enable_in <= 1'b1;
    i_tx_enable_in <= 1'b1;
    i_power_button_in <= 1'b0;
    cyc(4);
    chk(en, 8'h77);
    $display("boot test done");
  endtask
  task automatic t_off;
    i_osc_supply_enable_in <= 1'b0;
    i_tx_enable_in <= 1'b0;
    i_power_button_in <= 1'b1;
    cyc(4);
    chk(o_button_irq_n, 1'b0);
    i_power_button_in <= 1'b0;
    cyc(4);
    chk({en, o_button_irq_n}, 8'h01);
    $display("shutdown test done");
  endtask
  task automatic ser_bit(input logic b, output logic line);
    sda_drv <= b;
    cyc(4);
    i_scl <= 1'b1;
    cyc(4);
    line = i_sda;
    i_scl <= 1'b0;
    cyc(4);
  endtask
  task automatic ser_xfer(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d,
      input logic [7:0] ack_exp, output logic [7:0] got);
    logic [23:0] frame;
    logic [2:0] acks;
    frame = {a, r, d};
    sda_drv <= 1'b0;
    cyc(4);
    i_scl <= 1'b0;
    cyc(4);
    for (int n = 2; n >= 0; n--) begin
      for (int i = 7; i >= 0; i--) begin
        ser_bit(frame[n * 8 + i], got[i]);
      end
      ser_bit(1'b1, acks[n]);
    end
    sda_drv <= 1'b0;
    cyc(4);
    i_scl <= 1'b1;
    cyc(4);
    sda_drv <= 1'b1;
    cyc(4);
    chk(acks, ack_exp);
  endtask
  task automatic t_serial;
    logic [7:0] got;
    ser_xfer({SLAVE_ADDR, 1'b0}, BUCK_CTRL_ADDR, 8'h00, 8'h00, got);
    cyc(4);
    chk({o_buck_en, o_sda_out}, 8'h00);
    ser_xfer({SLAVE_ADDR, 1'b1}, BUCK_CTRL_ADDR, 8'hff, 8'h01, got);
    chk(got, 8'h01 << BUCK_OK_BIT);
    ser_xfer({~SLAVE_ADDR, 1'b0}, BUCK_CTRL_ADDR, 8'h01, 8'h07, got);
    cyc(4);
    chk(o_buck_en, 1'b0);
    ser_xfer({SLAVE_ADDR, 1'b0}, BUCK_CTRL_ADDR, 8'h01, 8'h00, got);
    ser_xfer({SLAVE_ADDR, 1'b0}, LDO_CTRL_ADDR, 8'h02, 8'h00, got);
    cyc(4);
    chk({o_buck_en, o_linear_reg_five_en}, 8'h03);
    $display("serial test done");
  endtask
  task automatic t_heat;
    i_over_temp <= 1'b1;
    cyc(4);
    chk({en, o_cpu_reset_n}, 8'h00);
    i_over_temp <= 1'b0;
    i_power_button_in <= 1'b1;
    cyc(4);
    chk(en, 8'h00);
    i_temp_cooled <= 1'b1;
    cyc(4);
    chk(o_buck_en, 1'b1);
    $display("thermal test done");
  endtask
  task automatic t_early;
    do_reset();
    boot_delay <= 8'hc8;
    {i_buck_at_87, i_linear_one_at_87, i_buck_in_window, i_linear_one_in_window} <= 4'hf;
    i_power_button_in <= 1'b1;
    wait_for(o_cpu_reset_n, 1'b1);
    i_power_button_in <= 1'b0;
    cyc(4);
    chk({en, o_cpu_reset_n}, 8'h00);
    boot_delay <= 8'h04;
    $display("early release test done");
  endtask

  initial begin
    t_wake();
    t_boot(1'b1);
    t_off();
    t_boot(1'b0);
    t_serial();
    t_heat();
    t_early();
    final_report();
  end
endmodule // pmu_power_sequencer_bench
